//--- logic/fba_core.v
// What this block does
// - An 8-bit volatile bank register supplies address bits 30 to 24 of every three-byte access.
// - With the bank register top bit set, addresses are four bytes and the bank bits are ignored.
// - With the top bit clear, addresses are three bytes and the bank bits pick the 128 Mbit segment.
// - Command 16h reads the bank register and 17h with exactly one data byte writes it.
// - Dedicated commands always take four address bytes whatever the mode bit says.
// - Four-byte mode ends when the mode bit is cleared, on hardware reset, soft reset or power cycle.
// - Command F0h performs a soft reset.
// - The configuration register is written only after 06h enabled writing, else the write is refused.
// - The discovery word for address mode and soft reset reads A8 FA 28 F0, top byte first.
// - Mode bits of 00h during continuous quad read end that mode at the end of the current read.
// - All ones on the four data lines for eight clocks ends continuous quad read before the next read.
`include "fba_consts.vh"

module fba_core (
    // System.
    input wire clk_sys,
    input wire rst_n,
    // Hardware reset pin, synchronous to clk_sys.
    input wire hw_reset_n,
    // Serial link, sampled on clk_sys.
    input wire spi_sck,
    input wire spi_cs_n,
    input wire [3:0] dq_in,
    output reg [3:0] dq_out_r,
    output reg [3:0] dq_oe_r,
    // Decoded access towards the array.
    output reg [31:0] mem_addr_r,
    output reg addr_valid_r,
    output reg [7:0] mem_cmd_r,
    // Register state.
    output reg [7:0] bank_r,
    output reg [7:0] cfg_r,
    output reg wel_r,
    output reg crm_r
);

    localparam ST_CMD = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_MODE = 3'd2;
    localparam ST_DUMMY = 3'd3;
    localparam ST_DIN = 3'd4;
    localparam ST_DOUT = 3'd5;
    localparam ST_SKIP = 3'd6;

    reg sck_q_r;
    reg cs_q_r;
    reg [2:0] st_r;
    reg [6:0] cnt_r;
    reg [31:0] sh_r;
    reg quad_r;
    reg [7:0] bank_cmd_r;
    reg cmd_ok_r;
    reg [7:0] out_r;
    reg [2:0] obit_r;
    reg [7:0] disc_ptr_r;
    reg [3:0] ones_r;
    reg crm_frame_r;
    wire [7:0] disc_byte;

    // Edge detection; inputs are already synchronous so no extra stages are needed.
    wire rise = ~spi_cs_n & spi_sck & ~sck_q_r;
    wire fall = ~spi_cs_n & ~spi_sck & sck_q_r;
    wire frame_start = cs_q_r & ~spi_cs_n;
    wire frame_end = ~cs_q_r & spi_cs_n;

    wire [31:0] sh_nxt = quad_r ? {sh_r[27:0], dq_in} : {sh_r[30:0], dq_in[0]};
    wire [6:0] step = quad_r ? 7'd4 : 7'd1;
    wire [6:0] cnt_sum = cnt_r + step;
    wire [6:0] dummy_sum = cnt_r + 7'd1;

    // Dedicated commands force four address bytes regardless of the mode bit.
    wire ded4 = (mem_cmd_r == `FBA_CMD_READ4) || (mem_cmd_r == `FBA_CMD_QIOR4);
    wire four_b = ded4 || bank_cmd_r[`FBA_BANK_MODE_BIT];
    wire [6:0] alen = four_b ? `FBA_ADDR4_BITS : `FBA_ADDR3_BITS;
    wire is_quad_rd = (mem_cmd_r == `FBA_CMD_QIOR) || (mem_cmd_r == `FBA_CMD_QIOR4);

    // Builds the array address from the captured bits and the frame's bank snapshot.
    function [31:0] full_addr;
        input four;
        input [7:0] bank;
        input [31:0] a;
        begin
            if (four) begin
                full_addr = a;
            end else begin
                full_addr = {1'b0, bank[6:0], a[23:0]};
            end
        end
    endfunction

    fba_disc_rom u_rom (
        .byte_addr(disc_ptr_r),
        .byte_data(disc_byte)
    );

    // One process owns the whole frame engine; rise and fall never coincide.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_q_r <= 1'b0;
            cs_q_r <= 1'b1;
            st_r <= ST_SKIP;
            cnt_r <= 7'h00;
            sh_r <= 32'h00000000;
            quad_r <= 1'b0;
            bank_cmd_r <= `FBA_BANK_RESET;
            cmd_ok_r <= 1'b0;
            out_r <= 8'h00;
            obit_r <= 3'h0;
            disc_ptr_r <= 8'h00;
            ones_r <= 4'h0;
            crm_frame_r <= 1'b0;
            dq_out_r <= 4'h0;
            dq_oe_r <= 4'h0;
            mem_addr_r <= 32'h00000000;
            addr_valid_r <= 1'b0;
            mem_cmd_r <= 8'h00;
            bank_r <= `FBA_BANK_RESET;
            cfg_r <= `FBA_CFG_RESET;
            wel_r <= 1'b0;
            crm_r <= 1'b0;
        end else begin
            sck_q_r <= spi_sck;
            cs_q_r <= spi_cs_n;
            addr_valid_r <= 1'b0;
            if (!hw_reset_n) begin
                // Hardware reset pin drops four-byte mode and any continuous read.
                bank_r <= `FBA_BANK_RESET;
                crm_r <= 1'b0;
                wel_r <= 1'b0;
                st_r <= ST_SKIP;
                dq_oe_r <= 4'h0;
            end else if (frame_start) begin
                // Snapshot the bank so a mid-frame write cannot move this access.
                bank_cmd_r <= bank_r;
                cnt_r <= 7'h00;
                cmd_ok_r <= 1'b0;
                ones_r <= 4'h0;
                crm_frame_r <= crm_r;
                // In continuous quad read the frame opens straight with the address.
                st_r <= crm_r ? ST_ADDR : ST_CMD;
                quad_r <= crm_r;
            end else if (frame_end) begin
                st_r <= ST_SKIP;
                dq_oe_r <= 4'h0;
                if (cmd_ok_r) begin
                    case (mem_cmd_r)
                        `FBA_CMD_WREN: begin
                            wel_r <= 1'b1;
                        end
                        `FBA_CMD_BANK_WR: begin
                            // Only a frame of exactly one data byte updates the bank.
                            if (st_r == ST_DIN && cnt_r[5:0] == `FBA_BANK_DATA_BITS) begin
                                bank_r <= sh_r[7:0];
                            end
                        end
                        `FBA_CMD_WRR: begin
                            // Without the write-enable latch the write is dropped.
                            if (wel_r && st_r == ST_DIN && cnt_r[5:0] == `FBA_CFG_DATA_BITS) begin
                                cfg_r <= sh_r[7:0];
                            end
                            wel_r <= 1'b0;
                        end
                        `FBA_CMD_SOFT_RST: begin
                            bank_r <= `FBA_BANK_RESET;
                            wel_r <= 1'b0;
                            crm_r <= 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (rise) begin
                sh_r <= sh_nxt;
                case (st_r)
                    ST_CMD: begin
                        cnt_r <= cnt_sum;
                        if (cnt_sum == `FBA_CMD_BITS) begin
                            mem_cmd_r <= sh_nxt[7:0];
                            cmd_ok_r <= 1'b1;
                            cnt_r <= 7'h00;
                            case (sh_nxt[7:0])
                                `FBA_CMD_BANK_RD: begin
                                    st_r <= ST_DOUT;
                                    out_r <= bank_r;
                                    obit_r <= 3'h0;
                                end
                                `FBA_CMD_BANK_WR, `FBA_CMD_WRR: begin
                                    st_r <= ST_DIN;
                                end
                                `FBA_CMD_READ, `FBA_CMD_READ4, `FBA_CMD_DISC_RD: begin
                                    st_r <= ST_ADDR;
                                end
                                `FBA_CMD_QIOR, `FBA_CMD_QIOR4: begin
                                    st_r <= ST_ADDR;
                                    quad_r <= 1'b1;
                                end
                                default: begin
                                    st_r <= ST_SKIP;
                                end
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        cnt_r <= cnt_sum;
                        // Eight clocks of all ones on the data lines leave continuous read.
                        if (crm_frame_r && dq_in == `FBA_DQ_ALL_ONES) begin
                            ones_r <= ones_r + 4'd1;
                        end else begin
                            ones_r <= 4'h0;
                        end
                        if (crm_frame_r && dq_in == `FBA_DQ_ALL_ONES && ones_r == `FBA_ONES_CLOCKS - 4'd1) begin
                            // With four address bytes the eight clocks of ones end inside the address.
                            crm_r <= 1'b0;
                            st_r <= ST_SKIP;
                        end else if (cnt_sum == alen) begin
                            mem_addr_r <= full_addr(four_b, bank_cmd_r, sh_nxt);
                            addr_valid_r <= 1'b1;
                            disc_ptr_r <= sh_nxt[7:0];
                            cnt_r <= 7'h00;
                            if (is_quad_rd) begin
                                st_r <= ST_MODE;
                            end else if (mem_cmd_r == `FBA_CMD_DISC_RD) begin
                                st_r <= ST_DUMMY;
                            end else begin
                                st_r <= ST_SKIP;
                            end
                        end
                    end
                    ST_MODE: begin
                        cnt_r <= cnt_sum;
                        ones_r <= (dq_in == `FBA_DQ_ALL_ONES) ? ones_r + 4'd1 : 4'h0;
                        if (crm_frame_r && dq_in == `FBA_DQ_ALL_ONES && ones_r == `FBA_ONES_CLOCKS - 4'd1) begin
                            crm_r <= 1'b0;
                            st_r <= ST_SKIP;
                        end else if (cnt_sum == `FBA_MODE_BITS) begin
                            // A5h keeps the mode; 00h or any other value ends it with this read.
                            crm_r <= (sh_nxt[7:0] == `FBA_MODE_STAY);
                            cnt_r <= 7'h00;
                            st_r <= ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        cnt_r <= dummy_sum;
                        if (is_quad_rd && dummy_sum == `FBA_QDUMMY_CLKS) begin
                            // Array data is served elsewhere; this block only steers the address.
                            st_r <= ST_SKIP;
                        end else if (!is_quad_rd && dummy_sum == `FBA_DDUMMY_CLKS) begin
                            st_r <= ST_DOUT;
                            out_r <= disc_byte;
                            obit_r <= 3'h0;
                        end
                    end
                    ST_DIN: begin
                        // Saturate so an over-long write is seen as wrong length.
                        if (cnt_r != 7'h3F) begin
                            cnt_r <= dummy_sum;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (fall && st_r == ST_DOUT) begin
                // Data leaves on the falling edge, top bit first, on the second data line.
                dq_out_r <= {2'b00, out_r[7], 1'b0};
                dq_oe_r <= 4'h2;
                obit_r <= obit_r + 3'd1;
                if (obit_r == 3'd7) begin
                    if (mem_cmd_r == `FBA_CMD_DISC_RD) begin
                        disc_ptr_r <= disc_ptr_r + 8'd1;
                        out_r <= 8'h00;
                    end else begin
                        out_r <= bank_r;
                    end
                end else begin
                    out_r <= {out_r[6:0], 1'b0};
                end
            end else if (st_r == ST_DOUT && obit_r == 3'd0 && mem_cmd_r == `FBA_CMD_DISC_RD && !sck_q_r) begin
                // Reload after the pointer step, before the next byte's first falling edge.
                out_r <= disc_byte;
            end
        end
    end

endmodule // fba_core

//--- logic/fba_consts.vh
`ifndef FBA_CONSTS_VH
`define FBA_CONSTS_VH

// Command opcodes taken from the serial line.
`define FBA_CMD_WREN 8'h06
`define FBA_CMD_WRR 8'h01
`define FBA_CMD_BANK_RD 8'h16
`define FBA_CMD_BANK_WR 8'h17
`define FBA_CMD_SOFT_RST 8'hF0
`define FBA_CMD_READ 8'h03
`define FBA_CMD_READ4 8'h13
`define FBA_CMD_QIOR 8'hEB
`define FBA_CMD_QIOR4 8'hEC
`define FBA_CMD_DISC_RD 8'h5A

// Bank register layout, and the reset values of the bank and configuration registers.
`define FBA_BANK_RESET 8'h00
`define FBA_BANK_MODE_BIT 7
`define FBA_CFG_RESET 8'h00

// Mode byte values of the quad read, and its all-ones exit pattern and clock count.
`define FBA_MODE_STAY 8'hA5
`define FBA_MODE_EXIT 8'h00
`define FBA_DQ_ALL_ONES 4'hF
`define FBA_ONES_CLOCKS 4'd8

// Bit counts of the frame phases, with the dummy phase lengths in clocks.
`define FBA_CMD_BITS 7'd8
`define FBA_ADDR3_BITS 7'd24
`define FBA_ADDR4_BITS 7'd32
`define FBA_MODE_BITS 7'd8
`define FBA_QDUMMY_CLKS 7'd4
`define FBA_DDUMMY_CLKS 7'd8
`define FBA_BANK_DATA_BITS 6'd8
`define FBA_CFG_DATA_BITS 6'd16

// Discovery word: byte offsets and contents, least significant byte at the lowest offset.
`define FBA_DISC_OFF0 8'h3C
`define FBA_DISC_OFF1 8'h3D
`define FBA_DISC_OFF2 8'h3E
`define FBA_DISC_OFF3 8'h3F
`define FBA_DISC_B0 8'hF0
`define FBA_DISC_B1 8'h28
`define FBA_DISC_B2 8'hFA
`define FBA_DISC_B3 8'hA8
`define FBA_DISC_BLANK 8'hFF

`endif

//--- logic/fba_disc_rom.v
`include "fba_consts.vh"

// Discovery table slice holding the address-mode word; unlisted offsets read as erased.
module fba_disc_rom (
    // Lookup.
    input wire [7:0] byte_addr,
    output reg [7:0] byte_data
);

    // Constant lookup so the word reads A8 FA 28 F0 from its top byte down.
    always @* begin
        case (byte_addr)
            `FBA_DISC_OFF0: byte_data = `FBA_DISC_B0;
            `FBA_DISC_OFF1: byte_data = `FBA_DISC_B1;
            `FBA_DISC_OFF2: byte_data = `FBA_DISC_B2;
            `FBA_DISC_OFF3: byte_data = `FBA_DISC_B3;
            default: byte_data = `FBA_DISC_BLANK;
        endcase
    end

endmodule // fba_disc_rom

//--- verification/fba_host.sv
module fba_host (
    // Clock and device answer.
    input wire logic clk_sys,
    input wire logic [3:0] dq_out,
    input wire logic [3:0] dq_oe,
    // Serial lines towards the device.
    output logic spi_sck,
    output logic spi_cs_n,
    output logic [3:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Three clocks a phase keeps sck well above the two-clock sampling limit.
    localparam int HALF = 3;
    // The serial clock rests low between frames, as mode 0 needs.
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        dq_in = 4'h0;
    end
    // Every line change lands on a falling edge, away from the sampling edge.
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // One sck period; the data is set while sck is low and held across the rise.
    task automatic pulse(input logic [3:0] v);
        dq_in = v;
        tick(HALF);
        spi_sck = 1'b1;
        tick(HALF);
        spi_sck = 1'b0;
    endtask
    // Opcode on line 0 unless skipped, then nb tail bits MSB first on one or four lines, then nrd read clocks.
    task automatic frame(input logic [7:0] cmd, input logic skip, input logic [63:0] tail, input int nb,
                         input logic quad, input int nrd, output logic [31:0] rd);
        int i;
        rd = 32'h0;
        tick(1);
        spi_cs_n = 1'b0;
        tick(HALF);
        if (!skip) begin
            for (i = 7; i >= 0; i--) pulse({3'b000, cmd[i]});
        end
        for (i = nb - 1; i >= 0; i -= (quad ? 4 : 1)) begin
            pulse(quad ? tail[i -: 4] : {3'b000, tail[i]});
        end
        for (i = 0; i < nrd; i++) begin
            tick(HALF);
            // A line left undriven reads as the inverse, so a missing enable shows up as bad data.
            rd = {rd[30:0], dq_oe[1] ? dq_out[1] : ~dq_out[1]};
            spi_sck = 1'b1;
            tick(HALF);
            spi_sck = 1'b0;
        end
        tick(HALF);
        spi_cs_n = 1'b1;
        dq_in = ~dq_in; // Released lines must not keep showing the last value.
        tick(4);
    endtask
endmodule // fba_host

//--- verification/fba_core_props.sv
module fba_core_props (
    // System.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hw_reset_n,
    input wire logic spi_cs_n,
    // Design outputs.
    input wire logic [3:0] dq_oe_r,
    input wire logic [31:0] mem_addr_r,
    input wire logic addr_valid_r,
    input wire logic [7:0] mem_cmd_r,
    input wire logic [7:0] bank_r,
    input wire logic [7:0] cfg_r,
    input wire logic wel_r,
    input wire logic crm_r
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    oe_pattern_a: assert property (dq_oe_r == 4'h0 || dq_oe_r == 4'h2)
        else $error("output enable pattern is illegal");
    oe_idle_a: assert property (spi_cs_n [*2] |=> dq_oe_r == 4'h0)
        else $error("data line driven while deselected");
    bank_quiet_a: assert property ($changed(bank_r) && $past(hw_reset_n) |-> spi_cs_n)
        else $error("bank register changed inside a frame");
    hw_clear_a: assert property (!hw_reset_n |=> bank_r == 8'h00 && !crm_r && !wel_r)
        else $error("hardware reset left state behind");
    valid_pulse_a: assert property (addr_valid_r |=> !addr_valid_r)
        else $error("address strobe longer than one cycle");
    seg_map_a: assert property (addr_valid_r && !bank_r[7] && (mem_cmd_r == 8'h03 || mem_cmd_r == 8'hEB)
        |-> mem_addr_r[31:24] == {1'b0, bank_r[6:0]}) else $error("upper address not taken from bank");
    addr_moves_a: assert property ($changed(mem_addr_r) && $past(hw_reset_n) |-> addr_valid_r)
        else $error("address moved without strobe");
    wel_set_a: assert property ($rose(wel_r) |-> spi_cs_n && mem_cmd_r == 8'h06)
        else $error("write enable set by a wrong command");
    cfg_guard_a: assert property ($changed(cfg_r) |-> $past(wel_r) || $past(wel_r, 2))
        else $error("configuration written without enable");
    crm_enter_a: assert property ($rose(crm_r) |-> mem_cmd_r == 8'hEB || mem_cmd_r == 8'hEC)
        else $error("continuous read entered by a wrong command");
endmodule // fba_core_props

bind fba_core fba_core_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .hw_reset_n(hw_reset_n), .spi_cs_n(spi_cs_n), .dq_oe_r(dq_oe_r),
    .mem_addr_r(mem_addr_r), .addr_valid_r(addr_valid_r), .mem_cmd_r(mem_cmd_r), .bank_r(bank_r),
    .cfg_r(cfg_r), .wel_r(wel_r), .crm_r(crm_r)
);

//--- verification/tb_spi_flash_bank_address_mode.sv
module tb_spi_flash_bank_address_mode;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hw_reset_n = 1'b1;
    logic spi_sck, spi_cs_n, addr_valid_r, wel_r, crm_r;
    logic [3:0] dq_in, dq_out_r, dq_oe_r;
    logic [7:0] mem_cmd_r, bank_r, cfg_r;
    logic [31:0] mem_addr_r, rd;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    // A 50 ns period.
    always #25 clk_sys = ~clk_sys;
    fba_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .hw_reset_n(hw_reset_n), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .dq_in(dq_in), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r), .mem_addr_r(mem_addr_r),
        .addr_valid_r(addr_valid_r), .mem_cmd_r(mem_cmd_r), .bank_r(bank_r), .cfg_r(cfg_r), .wel_r(wel_r),
        .crm_r(crm_r));
    fba_host host (.clk_sys(clk_sys), .dq_out(dq_out_r), .dq_oe(dq_oe_r), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .dq_in(dq_in));
    // Compare and count; a mismatch is reported at once.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A hung handshake would otherwise stall the run for ever.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic wr_bank(input logic [7:0] v);
        host.frame(8'h17, 1'b0, {56'h0, v}, 8, 1'b0, 0, rd);
    endtask
    // Bank write and readback, segment mapping, a refused long write and both address widths.
    task automatic t_bank();
        chk("bank at reset", 32'(bank_r), 32'h0);
        wr_bank(8'h05);
        host.frame(8'h16, 1'b0, 64'h0, 0, 1'b0, 8, rd);
        chk("bank readback", rd, 32'h05);
        host.frame(8'h03, 1'b0, 64'h123456, 24, 1'b0, 0, rd);
        chk("three byte address", mem_addr_r, 32'h05123456);
        host.frame(8'h17, 1'b0, 64'h8500, 16, 1'b0, 0, rd);
        chk("long bank write", 32'(bank_r), 32'h05);
        wr_bank(8'h85);
        host.frame(8'h03, 1'b0, 64'h0ABBCCDD, 32, 1'b0, 0, rd);
        chk("four byte address", mem_addr_r, 32'h0ABBCCDD);
        wr_bank(8'h00);
        chk("mode bit cleared", 32'(bank_r), 32'h0);
        host.frame(8'h03, 1'b0, 64'h000010, 24, 1'b0, 0, rd);
        chk("three byte again", mem_addr_r, 32'h00000010);
        host.frame(8'h13, 1'b0, 64'h0A000004, 32, 1'b0, 0, rd);
        chk("dedicated four byte", mem_addr_r, 32'h0A000004);
    endtask
    // Configuration write refused without enable, taken with it.
    task automatic t_cfg();
        host.frame(8'h01, 1'b0, 64'h003C, 16, 1'b0, 0, rd);
        chk("cfg unguarded", 32'(cfg_r), 32'h0);
        host.frame(8'h06, 1'b0, 64'h0, 0, 1'b0, 0, rd);
        chk("write enable", 32'(wel_r), 32'h1);
        host.frame(8'h01, 1'b0, 64'h003C, 16, 1'b0, 0, rd);
        chk("cfg written", 32'(cfg_r), 32'h3C);
    endtask
    // Discovery word at offsets 3Ch to 3Fh, assembled top byte first.
    task automatic t_disc();
        host.frame(8'h5A, 1'b0, 64'h00003C00, 32, 1'b0, 32, rd);
        chk("discovery word", {rd[7:0], rd[15:8], rd[23:16], rd[31:24]}, 32'hA8FA28F0);
    endtask
    // Continuous quad read left by mode bits and by ones, then a soft reset.
    task automatic t_quad();
        host.frame(8'hEB, 1'b0, 64'h000100A50000, 48, 1'b1, 0, rd);
        chk("quad entry", 32'(crm_r), 32'h1);
        host.frame(8'h00, 1'b1, 64'h000200000000, 48, 1'b1, 0, rd);
        chk("mode bits exit", 32'(crm_r), 32'h0);
        chk("quad address", mem_addr_r, 32'h00000200);
        host.frame(8'hEB, 1'b0, 64'h000100A50000, 48, 1'b1, 0, rd);
        host.frame(8'h00, 1'b1, 64'hFFFFFFFF, 32, 1'b1, 0, rd);
        chk("ones exit", 32'(crm_r), 32'h0);
        host.frame(8'hEC, 1'b0, 64'h0ABBCCDDA50000, 56, 1'b1, 0, rd);
        chk("quad four byte", mem_addr_r, 32'h0ABBCCDD);
        chk("quad four entry", 32'(crm_r), 32'h1);
        host.frame(8'h00, 1'b1, 64'hFFFFFFFF, 32, 1'b1, 0, rd);
        chk("ones exit four byte", 32'(crm_r), 32'h0);
        wr_bank(8'h81);
        host.frame(8'hF0, 1'b0, 64'h0, 0, 1'b0, 0, rd);
        chk("soft reset", 32'(bank_r), 32'h0);
    endtask
    // Hardware reset pulse clears four-byte mode.
    task automatic t_hw();
        wr_bank(8'h83);
        hw_reset_n = 1'b0;
        @(negedge clk_sys);
        hw_reset_n = 1'b1;
        @(negedge clk_sys);
        chk("hardware reset", 32'(bank_r), 32'h0);
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_bank();
        t_cfg();
        t_disc();
        t_quad();
        t_hw();
        report_and_stop();
    end
endmodule // tb_spi_flash_bank_address_mode
